// >>> rtl/acbm_top.sv
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acbm_top
  import acbm_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          CLOCK,
  input  wire logic          RST_N,
  input  wire logic [AW-1:0] AWADDR,
  input  wire logic          AWVALID,
  output logic               AWREADY,
  input  wire logic [31:0]   WDATA,
  input  wire logic [3:0]    WSTRB,
  input  wire logic          WVALID,
  output logic               WREADY,
  output logic [1:0]         BRESP,
  output logic               BVALID,
  input  wire logic          BREADY,
  input  wire logic [AW-1:0] ARADDR,
  input  wire logic          ARVALID,
  output logic               ARREADY,
  output logic [31:0]        RDATA,
  output logic [1:0]         RRESP,
  output logic               RVALID,
  input  wire logic          RREADY,
  input  wire logic          RX_SUB_VALID,
  input  wire logic          RX_SUB_B,
  input  wire logic          RX_BLOCK_START,
  input  wire logic          RX_C,
  input  wire logic          RX_U,
  input  wire logic          TX_SUB_VALID,
  input  wire logic          TX_SUB_B,
  input  wire logic          TX_BLOCK_START,
  output logic               TX_C,
  output logic               TX_U,
  input  wire logic          HW_MODE,
  input  wire logic          SCMS_FROM_SERIAL,
  input  wire logic          SERIAL_C_IN,
  input  wire logic          COPY_PERMIT,
  input  wire logic          FIRST_GENERATION_INPUT,
  output logic               IRQ_DE,
  output logic               IRQ_EF
);

  typedef struct packed {
    logic [23:0][15:0] d_cs;
    logic [23:0][15:0] e_cs;
    logic [23:0][15:0] f_cs;
    logic [23:0][15:0] d_u;
    logic [23:0][15:0] e_u;
    logic [23:0][15:0] f_u;
    logic [7:0]        rx_frame;
    logic [7:0]        tx_frame;
    logic [4:0]        cs_ctrl;
    logic [1:0]        irq_en;
    logic              u_block;
    logic              irq_de;
    logic              irq_ef;
    logic              tx_c;
    logic              tx_u;
  } acbm_state_t;

  acbm_state_t st;
  acbm_state_t next_st;

  logic          wr_en;
  logic [7:0]    wr_idx;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic          wr_ok;
  logic [7:0]    rd_idx;
  logic [31:0]   rd_data;
  logic          rd_ok;
  logic [183:0]  crc_in_a;
  logic [183:0]  crc_in_b;
  logic [7:0]    crc_a;
  logic [7:0]    crc_b;
  logic          de_xfer;
  logic          ef_xfer;
  logic          rx_done;
  logic          tx_start;
  logic [7:0]    rf;
  logic [7:0]    tf;
  logic [8:0]    uj;
  logic [4:0]    ew;
  logic [15:0]   rd_word;

  acbm_axil #(.AW(AW)) u_axil (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .awaddr  (AWADDR),
    .awvalid (AWVALID),
    .awready (AWREADY),
    .wdata   (WDATA),
    .wstrb   (WSTRB),
    .wvalid  (WVALID),
    .wready  (WREADY),
    .bresp   (BRESP),
    .bvalid  (BVALID),
    .bready  (BREADY),
    .araddr  (ARADDR),
    .arvalid (ARVALID),
    .arready (ARREADY),
    .rdata   (RDATA),
    .rresp   (RRESP),
    .rvalid  (RVALID),
    .rready  (RREADY),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  for (genvar i = 0; i < CS_WORDS - 1; i++) begin : g_crc
    assign crc_in_a[183-8*i -: 8] = st.e_cs[i][15:8];
    assign crc_in_b[183-8*i -: 8] = st.e_cs[i][7:0];
  end

  acbm_crc8 u_crc_a (.data(crc_in_a), .crc(crc_a));
  acbm_crc8 u_crc_b (.data(crc_in_b), .crc(crc_b));

  assign IRQ_DE = st.irq_de;
  assign IRQ_EF = st.irq_ef;
  assign TX_C   = st.tx_c;
  assign TX_U   = st.tx_u;

  // Register read decode; the host stage windows and four control and status registers are the whole map.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    rd_word = 16'h0000;
    if (acbm_in_win(rd_idx, IDX_CS_BASE)) begin
      rd_word = st.e_cs[5'(rd_idx - IDX_CS_BASE)];
      if (st.cs_ctrl[B_ONE_BYTE]) begin
        rd_data = {24'h00_0000, st.cs_ctrl[B_SEL_B] ? rd_word[7:0] : rd_word[15:8]};
      end else begin
        rd_data = {16'h0000, rd_word};
      end
    end else if (acbm_in_win(rd_idx, IDX_U_BASE)) begin
      rd_data = {16'h0000, st.e_u[5'(rd_idx - IDX_U_BASE)]};
    end else if (rd_idx == IDX_CS_CTRL) begin
      rd_data = {27'h000_0000, st.cs_ctrl};
    end else if (rd_idx == IDX_U_CTRL) begin
      rd_data = {31'h0000_0000, st.u_block};
    end else if (rd_idx == IDX_IRQ_EN) begin
      rd_data = {30'h0000_0000, st.irq_en};
    end else if (rd_idx == IDX_STATUS) begin
      rd_data = {16'h0000, st.tx_frame, st.rx_frame};
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign wr_ok = acbm_in_win(wr_idx, IDX_CS_BASE) || acbm_in_win(wr_idx, IDX_U_BASE)
              || wr_idx == IDX_CS_CTRL || wr_idx == IDX_U_CTRL || wr_idx == IDX_IRQ_EN
              || wr_idx == IDX_STATUS;

  always_comb begin
    next_st  = st;
    next_st.irq_de = 1'b0;
    next_st.irq_ef = 1'b0;
    de_xfer  = 1'b0;
    ef_xfer  = 1'b0;
    rf       = (RX_BLOCK_START && !RX_SUB_B) ? 8'h00 : st.rx_frame;
    tf       = (TX_BLOCK_START && !TX_SUB_B) ? 8'h00 : st.tx_frame;
    uj       = {rf, RX_SUB_B};
    ew       = 5'h00;
    rx_done  = RX_SUB_VALID && RX_SUB_B && rf == LAST_FRAME;
    tx_start = TX_SUB_VALID && TX_BLOCK_START && !TX_SUB_B;

    // Receive stage: frame f sits in word f/8, earliest bit at the MSB.
    if (RX_SUB_VALID) begin
      next_st.d_cs[rf[7:3]][{~RX_SUB_B, ~rf[2:0]}] = RX_C;
      next_st.d_u[uj[8:4]][~uj[3:0]] = RX_U;
      if (RX_SUB_B) begin
        next_st.rx_frame = (rf == LAST_FRAME) ? 8'h00 : rf + 8'h01;
      end else begin
        next_st.rx_frame = rf;
      end
    end

    // A boundary under inhibit is simply lost, never held for later.
    if (rx_done && !st.cs_ctrl[B_DE_INH]) begin
      de_xfer = 1'b1;
      for (int w = 0; w < CS_WORDS; w++) begin
        if (!(st.cs_ctrl[B_RESERVE] && w < int'(RESERVED_WDS))) begin
          next_st.e_cs[w] = next_st.d_cs[w];
        end
      end
      next_st.e_u    = next_st.d_u;
      next_st.irq_de = st.irq_en[B_IRQ_DE];
    end

    if (tx_start && !st.cs_ctrl[B_EF_INH]) begin
      ef_xfer        = 1'b1;
      next_st.f_cs   = st.e_cs;
      next_st.f_u    = st.e_u;
      next_st.irq_ef = st.irq_en[B_IRQ_EF];
      if (st.e_cs[0][15]) begin
        next_st.f_cs[CRC_WORD][15:8] = crc_a;
      end
      if (st.e_cs[0][7]) begin
        next_st.f_cs[CRC_WORD][7:0] = crc_b;
      end
    end

    // Transmit stage feeds the serializer one bit per subframe.
    if (TX_SUB_VALID) begin
      next_st.tx_c = next_st.f_cs[tf[7:3]][{~TX_SUB_B, ~tf[2:0]}];
      if (HW_MODE && SCMS_FROM_SERIAL) begin
        next_st.tx_c = SERIAL_C_IN;
      end else if (HW_MODE && tf == COPY_FRAME) begin
        next_st.tx_c = COPY_PERMIT;
      end else if (HW_MODE && tf == GEN_FRAME) begin
        next_st.tx_c = FIRST_GENERATION_INPUT;
      end
      next_st.tx_u = st.u_block && next_st.f_u[tf[7:3]][~{tf[2:0], TX_SUB_B}];
      if (TX_SUB_B) begin
        next_st.tx_frame = (tf == LAST_FRAME) ? 8'h00 : tf + 8'h01;
      end else begin
        next_st.tx_frame = tf;
      end
    end

    // Host writes land after the receive transfer, so a same-cycle write wins.
    if (wr_en) begin
      if (acbm_in_win(wr_idx, IDX_CS_BASE)) begin
        ew = 5'(wr_idx - IDX_CS_BASE);
        if (st.cs_ctrl[B_ONE_BYTE]) begin
          if (wr_strb[0]) begin
            next_st.e_cs[ew] = {wr_data[7:0], wr_data[7:0]};
          end
        end else begin
          if (wr_strb[1]) begin
            next_st.e_cs[ew][15:8] = wr_data[15:8];
          end
          if (wr_strb[0]) begin
            next_st.e_cs[ew][7:0] = wr_data[7:0];
          end
        end
      end else if (acbm_in_win(wr_idx, IDX_U_BASE)) begin
        ew = 5'(wr_idx - IDX_U_BASE);
        if (wr_strb[1]) begin
          next_st.e_u[ew][15:8] = wr_data[15:8];
        end
        if (wr_strb[0]) begin
          next_st.e_u[ew][7:0] = wr_data[7:0];
        end
      end else if (wr_strb[0]) begin
        if (wr_idx == IDX_CS_CTRL) begin
          next_st.cs_ctrl = wr_data[4:0];
        end else if (wr_idx == IDX_U_CTRL) begin
          next_st.u_block = wr_data[B_U_BLOCK];
        end else if (wr_idx == IDX_IRQ_EN) begin
          next_st.irq_en = wr_data[1:0];
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_de_copy: assert property (@(posedge CLOCK) disable iff (!RST_N)
    de_xfer && !wr_en |=> st.e_u == $past(next_st.d_u))
    else $error("user block not copied to host stage");

  a_de_inhibit: assert property (@(posedge CLOCK) disable iff (!RST_N)
    rx_done && st.cs_ctrl[B_DE_INH] && !wr_en |=> $stable(st.e_cs) && !IRQ_DE)
    else $error("inhibited receive transfer changed host stage");

  a_ef_inhibit: assert property (@(posedge CLOCK) disable iff (!RST_N)
    tx_start && st.cs_ctrl[B_EF_INH] |=> $stable(st.f_cs) && !IRQ_EF)
    else $error("inhibited transmit transfer changed transmit stage");

  a_reserve_keep: assert property (@(posedge CLOCK) disable iff (!RST_N)
    de_xfer && st.cs_ctrl[B_RESERVE] && !wr_en |=> st.e_cs[4:0] == $past(st.e_cs[4:0]))
    else $error("reserved bytes overwritten");

  a_irq_de: assert property (@(posedge CLOCK) disable iff (!RST_N)
    IRQ_DE |-> $past(de_xfer) && $past(st.irq_en[B_IRQ_DE]))
    else $error("receive interrupt without enabled transfer");

  a_crc_fill: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ef_xfer && st.e_cs[0][15] |=> st.f_cs[CRC_WORD][15:8] == $past(crc_a))
    else $error("professional CRCC not placed");

  a_umode_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
    TX_SUB_VALID && !st.u_block |=> !TX_U ##1 (!$past(TX_SUB_VALID) || $past(st.u_block) || !TX_U))
    else $error("user mode 1 sent a one");

  a_one_wr: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_en && wr_strb[0] && st.cs_ctrl[B_ONE_BYTE] && acbm_in_win(wr_idx, IDX_CS_BASE)
    |=> st.e_cs[$past(ew)] == {2{$past(wr_data[7:0])}})
    else $error("one-byte write not mirrored");

  a_sel_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st.cs_ctrl[B_ONE_BYTE] && st.cs_ctrl[B_SEL_B] && acbm_in_win(rd_idx, IDX_CS_BASE)
    |-> rd_data == {24'h00_0000, st.e_cs[5'(rd_idx - IDX_CS_BASE)][7:0]})
    else $error("one-byte read took wrong channel");

endmodule // acbm_top
`default_nettype wire

// >>> rtl/acbm_pkg.sv
`default_nettype none
package acbm_pkg;

  localparam int          CS_WORDS     = 24;
  localparam logic [7:0]  LAST_FRAME   = 8'hBF;
  localparam logic [4:0]  RESERVED_WDS = 5'h05;
  localparam logic [4:0]  CRC_WORD     = 5'h17;
  localparam logic [7:0]  CRC_INIT     = 8'hFF;
  localparam logic [7:0]  CRC_POLY     = 8'h1D;

  // Register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_STATUS   = 8'h07;
  localparam logic [7:0]  IDX_IRQ_EN   = 8'h09;
  localparam logic [7:0]  IDX_CS_CTRL  = 8'h12;
  localparam logic [7:0]  IDX_U_CTRL   = 8'h13;
  localparam logic [7:0]  IDX_CS_BASE  = 8'h20;
  localparam logic [7:0]  IDX_U_BASE   = 8'h40;

  // Field positions in the buffer control registers.
  localparam int          B_EF_INH     = 0;
  localparam int          B_DE_INH     = 1;
  localparam int          B_RESERVE    = 2;
  localparam int          B_ONE_BYTE   = 3;
  localparam int          B_SEL_B      = 4;
  localparam int          B_IRQ_DE     = 0;
  localparam int          B_IRQ_EF     = 1;
  localparam int          B_U_BLOCK    = 0;

  // Channel status bit positions used for copy management: copy permit and generation status.
  localparam logic [7:0]  COPY_FRAME   = 8'h02;
  localparam logic [7:0]  GEN_FRAME    = 8'h0F;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  function automatic logic acbm_in_win(input logic [7:0] idx, input logic [7:0] base);
    acbm_in_win = (idx >= base) && (idx < base + 8'h18);
  endfunction

endpackage
`default_nettype wire

// >>> rtl/acbm_crc8.sv
`timescale 1ns/1ps
`default_nettype none
module acbm_crc8
  import acbm_pkg::*;
(
  input  wire logic [183:0] data,
  output logic      [7:0]   crc
);

  // Stream order: data[183] is the first bit of the block.
  function automatic logic [7:0] acbm_crc(input logic [183:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 183; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    acbm_crc = c;
  endfunction

  assign crc = acbm_crc(data);

endmodule // acbm_crc8
`default_nettype wire

// >>> rtl/acbm_axil.sv
`timescale 1ns/1ps
`default_nettype none
module acbm_axil
  import acbm_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  output logic               wr_en,
  output logic [7:0]         wr_idx,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_ok,
  output logic [7:0]         rd_idx,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_ok
);

  typedef struct packed {
    logic          aw_full;
    logic [AW-1:0] aw_addr;
    logic          w_full;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          b_valid;
    logic [1:0]    b_resp;
    logic          r_valid;
    logic [31:0]   r_data;
    logic [1:0]    r_resp;
  } acbm_axil_t;

  acbm_axil_t st;
  acbm_axil_t next_st;
  logic [8:0] aw_index;
  logic [8:0] ar_index;

  // Addresses beyond the index range decode as unmapped.
  function automatic logic [8:0] acbm_index(input logic [AW-1:0] a);
    acbm_index = {(a >> 10) != '0, a[9:2]};
  endfunction

  assign awready = !st.aw_full;
  assign wready  = !st.w_full;
  assign arready = !st.r_valid;
  assign bvalid  = st.b_valid;
  assign bresp   = st.b_resp;
  assign rvalid  = st.r_valid;
  assign rdata   = st.r_data;
  assign rresp   = st.r_resp;
  assign wr_en   = st.aw_full && st.w_full && !st.b_valid;
  assign aw_index = acbm_index(st.aw_addr);
  assign ar_index = acbm_index(araddr);
  assign wr_idx  = aw_index[7:0];
  assign wr_data = st.w_data;
  assign wr_strb = st.w_strb;
  assign rd_idx  = ar_index[7:0];

  always_comb begin
    next_st = st;
    if (awvalid && awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (wr_en) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.b_valid = 1'b1;
      next_st.b_resp  = (wr_ok && !aw_index[8]) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      next_st.b_valid = 1'b0;
    end
    if (arvalid && arready) begin
      next_st.r_valid = 1'b1;
      next_st.r_data  = rd_data;
      next_st.r_resp  = (rd_ok && !ar_index[8]) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      next_st.r_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_bresp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");

endmodule // acbm_axil
`default_nettype wire

// >>> tb/acbm_host.sv
`timescale 1ns/1ps
`default_nettype none
// Control port master; each wait is bounded so a dead slave cannot hang the run.
module acbm_host (
  input  wire logic        clk,
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int tmo = 0;

  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    bit done;
    done = 0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 64 && !done; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) tmo++;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    d = '0;
    r = 2'h3;
    @(posedge clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 64 && !done; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) tmo++;
  endtask
endmodule // acbm_host
`default_nettype wire

// >>> tb/acbm_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module acbm_top_bench
  import acbm_pkg::*;
;
  logic        CLOCK = 1'b0;
  logic        RST_N = 1'b0;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic        RX_SUB_VALID, RX_SUB_B, RX_BLOCK_START, RX_C, RX_U;
  logic        TX_SUB_VALID, TX_SUB_B, TX_BLOCK_START, TX_C, TX_U, IRQ_DE, IRQ_EF;
  logic        HW_MODE, SCMS_FROM_SERIAL, SERIAL_C_IN, COPY_PERMIT, FIRST_GENERATION_INPUT;
  logic [15:0] dc[24], du[24], ec[24], eu[24], fc[24], fu[24];
  int          failures = 0;
  int          n_checks = 0;
  int          n_de = 0;
  int          n_ef = 0;

  always #25 CLOCK = ~CLOCK;

  acbm_top #(.AW(12)) i_acbm_top (
    .CLOCK(CLOCK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .RX_SUB_VALID(RX_SUB_VALID), .RX_SUB_B(RX_SUB_B), .RX_BLOCK_START(RX_BLOCK_START),
    .RX_C(RX_C), .RX_U(RX_U), .TX_SUB_VALID(TX_SUB_VALID), .TX_SUB_B(TX_SUB_B),
    .TX_BLOCK_START(TX_BLOCK_START), .TX_C(TX_C), .TX_U(TX_U), .HW_MODE(HW_MODE),
    .SCMS_FROM_SERIAL(SCMS_FROM_SERIAL), .SERIAL_C_IN(SERIAL_C_IN),
    .COPY_PERMIT(COPY_PERMIT), .FIRST_GENERATION_INPUT(FIRST_GENERATION_INPUT),
    .IRQ_DE(IRQ_DE), .IRQ_EF(IRQ_EF));

  acbm_host i_acbm_host (
    .clk(CLOCK), .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY), .wdata(WDATA),
    .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY), .bresp(BRESP), .bvalid(BVALID),
    .bready(BREADY), .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
    .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY));

  // Counting high cycles catches both a missing pulse and one that lingers.
  always @(posedge CLOCK) begin
    n_de <= n_de + (IRQ_DE ? 1 : 0);
    n_ef <= n_ef + (IRQ_EF ? 1 : 0);
  end

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    i_acbm_host.wr(idx, d, s, r);
    if (i_acbm_host.tmo != 0) begin
      failures++;
      final_report();
    end else begin
      chk("bresp", {30'h0, er}, {30'h0, r});
    end
  endtask

  task automatic rd(input logic [7:0] idx, input string nm, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  r;
    i_acbm_host.rd(idx, v, r);
    if (i_acbm_host.tmo != 0) begin
      failures++;
      final_report();
    end else begin
      chk(nm, e, v & m);
      chk("rresp", {30'h0, er}, {30'h0, r});
    end
  endtask

  function automatic logic [7:0] crc8(input bit b);
    logic [7:0] c, x;
    c = CRC_INIT;
    for (int i = 0; i < 23; i++) begin
      x = b ? fc[i][7:0] : fc[i][15:8];
      for (int k = 7; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ x[k]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  task automatic check_e(input bit u);
    for (int i = 0; i < 24; i++) begin
      rd(IDX_CS_BASE + 8'(i), "cs_word", {16'h0, ec[i]}, 32'h0000_ffff, RESP_OKAY);
      if (u) rd(IDX_U_BASE + 8'(i), "u_word", {16'h0, eu[i]}, 32'h0000_ffff, RESP_OKAY);
    end
  endtask

  task automatic rx_block(input bit inh, input bit rsv);
    int d0;
    logic c, u;
    d0 = n_de;
    for (int f = 0; f < 192; f++) for (int b = 0; b < 2; b++) begin
      {c, u} = 2'($urandom);
      @(posedge CLOCK);
      RX_SUB_VALID <= 1'b1;
      RX_SUB_B <= b[0];
      RX_BLOCK_START <= (f == 0 && b == 0);
      RX_C <= c;
      RX_U <= u;
      dc[f/8][b ? 7 - f%8 : 15 - f%8] = c;
      du[(2*f + b)/16][15 - (2*f + b)%16] = u;
      @(posedge CLOCK);
      RX_SUB_VALID <= 1'b0;
    end
    repeat (4) @(posedge CLOCK);
    for (int i = 0; i < 24; i++) if (!inh) begin
      if (!(rsv && i < 5)) ec[i] = dc[i];
      eu[i] = du[i];
    end
    chk("irq_de_cycles", inh ? 32'h0 : 32'h1, n_de - d0);
  endtask

  // Mode hw: 0 software, 1 copy pins, 2 serial status input.
  task automatic tx_block(input bit inh, input bit um, input bit [1:0] hw);
    int         e0;
    logic [2:0] p;
    logic       ce;
    e0 = n_ef;
    if (!inh) begin
      fc = ec;
      fu = eu;
      if (fc[0][15]) fc[23][15:8] = crc8(0);
      if (fc[0][7]) fc[23][7:0] = crc8(1);
    end
    for (int f = 0; f < 192; f++) for (int b = 0; b < 2; b++) begin
      p = 3'($urandom);
      ce = fc[f/8][b ? 7 - f%8 : 15 - f%8];
      if (hw[0] && f == int'(COPY_FRAME)) ce = p[1];
      if (hw[0] && f == int'(GEN_FRAME)) ce = p[2];
      if (hw[1]) ce = p[0];
      @(posedge CLOCK);
      TX_SUB_VALID <= 1'b1;
      TX_SUB_B <= b[0];
      TX_BLOCK_START <= (f == 0 && b == 0);
      HW_MODE <= |hw;
      SCMS_FROM_SERIAL <= hw[1];
      {FIRST_GENERATION_INPUT, COPY_PERMIT, SERIAL_C_IN} <= p;
      @(posedge CLOCK);
      TX_SUB_VALID <= 1'b0;
      @(negedge CLOCK);
      chk("tx_c", {31'h0, ce}, {31'h0, TX_C});
      chk("tx_u", {31'h0, um & fu[(2*f + b)/16][15 - (2*f + b)%16]}, {31'h0, TX_U});
    end
    repeat (4) @(posedge CLOCK);
    chk("irq_ef_cycles", inh ? 32'h0 : 32'h1, n_ef - e0);
  endtask

  initial begin
    logic [31:0] s;
    {RX_SUB_VALID, RX_SUB_B, RX_BLOCK_START, RX_C, RX_U} = '0;
    {TX_SUB_VALID, TX_SUB_B, TX_BLOCK_START} = '0;
    {HW_MODE, SCMS_FROM_SERIAL, SERIAL_C_IN, COPY_PERMIT, FIRST_GENERATION_INPUT} = '0;
    for (int i = 0; i < 24; i++) {dc[i], du[i], ec[i], eu[i], fc[i], fu[i]} = '0;
    s = $urandom(32'ha07b_e6f6);
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    rd(IDX_CS_CTRL, "cs_ctrl", 32'h0, 32'h0000_001f, RESP_OKAY);
    rd(IDX_IRQ_EN, "irq_en", 32'h0, 32'h0000_0003, RESP_OKAY);
    rd(IDX_CS_BASE, "cs_word", 32'h0, 32'h0000_ffff, RESP_OKAY);
    rd(8'h08, "unmapped", 32'h0, 32'hffff_ffff, RESP_SLVERR);
    wr(8'h08, 32'h1234_5678, 4'hf, RESP_SLVERR);
    wr(IDX_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
    wr(IDX_IRQ_EN, 32'h0000_0003, 4'hf, RESP_OKAY);
    wr(IDX_U_CTRL, 32'h0000_0001, 4'hf, RESP_OKAY);
    rx_block(0, 0);
    // Reading straight after the transfer, with nothing inhibited, is safe.
    check_e(1);
    wr(IDX_CS_CTRL, 32'h0000_0002, 4'hf, RESP_OKAY);
    ec[0] = ec[0] | 16'ha0a0;
    wr(IDX_CS_BASE, {16'h0, ec[0]}, 4'h3, RESP_OKAY);
    rx_block(1, 0);
    check_e(0);
    tx_block(0, 1, 2'd0);
    wr(IDX_CS_CTRL, 32'h0000_0003, 4'hf, RESP_OKAY);
    wr(IDX_U_CTRL, 32'h0000_0000, 4'hf, RESP_OKAY);
    s = $urandom;
    ec[5] = s[15:0];
    wr(IDX_CS_BASE + 8'h05, {16'h0, ec[5]}, 4'h3, RESP_OKAY);
    tx_block(1, 0, 2'd1);
    tx_block(1, 0, 2'd2);
    wr(IDX_CS_CTRL, 32'h0000_0008, 4'hf, RESP_OKAY);
    rd(IDX_CS_BASE + 8'h01, "one_byte_a", {24'h0, ec[1][15:8]}, 32'h0000_00ff, RESP_OKAY);
    wr(IDX_CS_CTRL, 32'h0000_0018, 4'hf, RESP_OKAY);
    rd(IDX_CS_BASE + 8'h01, "one_byte_b", {24'h0, ec[1][7:0]}, 32'h0000_00ff, RESP_OKAY);
    s = $urandom;
    ec[6] = {s[7:0], s[7:0]};
    wr(IDX_CS_BASE + 8'h06, {24'h0, s[7:0]}, 4'h1, RESP_OKAY);
    wr(IDX_CS_CTRL, 32'h0000_0004, 4'hf, RESP_OKAY);
    rd(IDX_CS_BASE + 8'h06, "cs_word", {16'h0, ec[6]}, 32'h0000_ffff, RESP_OKAY);
    rx_block(0, 1);
    check_e(0);
    final_report();
  end
endmodule // acbm_top_bench
`default_nettype wire
